// *** rtl/pic_params.svh ***
// Register selects, field positions, reset values and status codes of the controller
// How it works
// - Pointer register holds three-bit indirect index
// - Indirect field reaches register picked by pointer
// - Data register holds byte to send/received
// - Master slave address sits in data register
// - Data stable while interrupt set, holds last
// - One byte, or 68 buffered, per interrupt
// - Own address byte captured as plain data
// - Byte mode: arbitration loss overwrites data
// - Buffered mode: arbitration loss keeps data
// - Data bit one means SDA high
// - Hardware sets interrupt flag on request
// - Bus STOP clears the stop request flag
// - Control write clears flag, releases line, SCL
// - Ack flag set: drive SDA low on ack
// - Ack flag clear: leave SDA high on ack
// - After C8h and clear, stop being addressed
// - Released slave ignores address, no interrupt
// - Released slave resumes recognition once ack set
// - Interrupt flag holds SCL low, never pulls high
// - Two select pins pick the direct register
// - Status F8h idle, others raise interrupt
// - Control bits 2:1 read as zero
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH
`define PIC_SEL_PTR_STAT  2'h0
`define PIC_SEL_DATA      2'h1
`define PIC_SEL_IND       2'h2
`define PIC_SEL_CTRL      2'h3
`define PIC_CTRL_AA       7
`define PIC_CTRL_ENABLE   6
`define PIC_CTRL_START    5
`define PIC_CTRL_STOP     4
`define PIC_CTRL_SI       3
`define PIC_CTRL_RSV_HI   2
`define PIC_CTRL_RSV_LO   1
`define PIC_CTRL_MODE     0
`define PIC_PTR_HI        2
`define PIC_RST_PTR       3'h0
`define PIC_RST_DATA      8'h00
`define PIC_ST_IDLE       8'hF8
`define PIC_ST_SLV_LAST   8'hC8
`define PIC_XFER_W        7
`define PIC_XFER_BYTE     7'h01
`define PIC_XFER_BUF      7'h44
`endif

// *** rtl/pic_pkg.sv ***
// Types shared by the controller register set
package pic_pkg;
  typedef enum logic [1:0] {
    PIC_ACK_NONE,
    PIC_ACK_OWN_ADDR,
    PIC_ACK_MST_RX,
    PIC_ACK_SLV_RX
  } pic_ack_case_e;
  typedef enum logic [1:0] {
    PIC_SLV_LISTEN,
    PIC_SLV_RELEASE_PEND,
    PIC_SLV_RELEASED
  } pic_slv_e;
  typedef struct packed {
    logic [7:0] data;
    logic       arb_lost;
    logic       own_addr;
  } pic_rx_s;
  typedef struct packed {
    logic aa;
    logic enable;
    logic start;
    logic stop;
    logic si;
    logic mode;
  } pic_ctrl_s;
  typedef struct packed {
    logic [2:0] sel;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } pic_ind_s;
endpackage

// *** rtl/pic_skid.sv ***
// Small FIFO between received-byte source and the data register
`timescale 1ns/1ps
module pic_skid #(
  parameter int W     = 10,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          in_ready_ff;
  wire           push = in_valid & in_ready_ff;
  wire           pop  = out_valid & out_ready;
  assign nxt_cnt   = cnt_ff + CW'(push) - CW'(pop);
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem[rptr_ff];
  assign in_ready  = in_ready_ff;
  always_ff @(posedge clk_sys) begin
    if (push) mem[wptr_ff] <= in_data;
  end
  // Ready is registered so the top output comes from a flop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wptr_ff     <= '0;
      rptr_ff     <= '0;
      cnt_ff      <= '0;
      in_ready_ff <= 1'h1;
    end else begin
      if (push) wptr_ff <= (wptr_ff == LAST) ? '0 : wptr_ff + AW'(1);
      if (pop)  rptr_ff <= (rptr_ff == LAST) ? '0 : rptr_ff + AW'(1);
      cnt_ff      <= nxt_cnt;
      in_ready_ff <= (nxt_cnt != FULL);
    end
  end
endmodule // pic_skid

// *** rtl/pic_line.sv ***
// SCL stretch and SDA acknowledge drive of the controller
`timescale 1ns/1ps
module pic_line
  import pic_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic          scl_in,
  input  wire logic          hold_req,
  input  wire logic          ack_slot,
  input  wire pic_ack_case_e ack_case,
  input  wire logic          ack_assert,
  input  wire logic          recog_en,
  output logic               scl_oe,
  output logic               sda_oe
);
  logic scl_hold_ff;
  logic sda_low_ff;
  // Only grab SCL once it is already low, a high level is left alone
  wire  nxt_scl_hold = hold_req & (~scl_in | scl_hold_ff);
  wire  case_ok      = (ack_case == PIC_ACK_MST_RX) | (ack_case == PIC_ACK_SLV_RX) |
                       ((ack_case == PIC_ACK_OWN_ADDR) & recog_en);
  wire  nxt_sda_low  = ack_slot & ack_assert & case_ok;
  assign scl_oe = scl_hold_ff;
  assign sda_oe = sda_low_ff;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_hold_ff <= 1'h0;
      sda_low_ff  <= 1'h0;
    end else begin
      scl_hold_ff <= nxt_scl_hold;
      sda_low_ff  <= nxt_sda_low;
    end
  end
endmodule // pic_line

// *** rtl/pic_regs.sv ***
// Directly addressed register set of the parallel to serial-bus controller
`timescale 1ns/1ps
`include "pic_params.svh"
module pic_regs (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   cs_n,
  input  wire logic                   wr_n,
  input  wire logic                   rd_n,
  input  wire logic                   register_select_low,
  input  wire logic                   register_select_high,
  input  wire logic [7:0]             host_data_in,
  output logic [7:0]                  host_data_out,
  output logic                        host_data_oe,
  output logic                        int_n_out,
  output logic                        int_n_oe,
  input  wire logic                   scl_in,
  output logic                        scl_out,
  output logic                        scl_oe,
  output logic                        sda_out,
  output logic                        sda_oe,
  input  wire logic                   evt_valid,
  input  wire logic [7:0]             evt_status,
  input  wire logic                   evt_own_addr,
  input  wire logic [7:0]             bus_status_code,
  input  wire logic                   start_det,
  input  wire logic                   stop_det,
  input  wire logic                   ack_slot,
  input  wire pic_pkg::pic_ack_case_e ack_case,
  input  wire logic                   buffered_mode,
  input  wire logic                   rx_valid,
  output logic                        rx_ready,
  input  wire pic_pkg::pic_rx_s       rx_data,
  output logic [7:0]                  tx_byte,
  output pic_pkg::pic_ctrl_s          ctrl,
  output logic                        recog_en,
  output pic_pkg::pic_ind_s           ind,
  input  wire logic [7:0]             ind_rdata,
  output logic                        buf_wr,
  output logic                        buf_rd,
  output logic [7:0]                  buf_wdata,
  input  wire logic [7:0]             buf_rdata
);
  import pic_pkg::*;

  //////////////////////////////////////////////////////////////////////////////////
  // Declarations
  pic_ctrl_s             ctrl_ff;
  pic_ctrl_s             nxt_ctrl;
  pic_ind_s              ind_ff;
  pic_ind_s              nxt_ind;
  pic_slv_e              slv_ff;
  pic_slv_e              nxt_slv;
  pic_rx_s               rxq_data;
  logic [7:0]            data_ff;
  logic [7:0]            nxt_data;
  logic [`PIC_XFER_W-1:0] xfer_ff;
  logic [`PIC_XFER_W-1:0] nxt_xfer;
  logic [7:0]            dout_ff;
  logic                  doe_ff;
  logic                  int_oe_ff;
  logic                  pin_low_ff;
  logic                  wr_act_ff;
  logic                  rd_act_ff;
  logic                  si_pend_ff;
  logic                  nxt_si_pend;
  logic                  recog_ff;
  logic                  buf_wr_ff;
  logic                  buf_rd_ff;
  logic [7:0]            buf_wdata_ff;
  logic                  rxq_valid;
  logic                  rxq_ready;
  logic [7:0]            ctrl_rdata;
  logic [7:0]            rd_mux;

  //////////////////////////////////////////////////////////////////////////////////
  // Host strobes and register selection
  wire [1:0] sel     = {register_select_high, register_select_low};
  wire       wr_act  = ~cs_n & ~wr_n;
  wire       rd_act  = ~cs_n & ~rd_n;
  // Act once per access on the leading edge, long strobes do not repeat
  wire       wr_fire = wr_act & ~wr_act_ff;
  wire       rd_fire = rd_act & ~rd_act_ff;
  wire       ptr_wr  = wr_fire & (sel == `PIC_SEL_PTR_STAT);
  wire       dat_wr  = wr_fire & (sel == `PIC_SEL_DATA);
  wire       dat_rd  = rd_fire & (sel == `PIC_SEL_DATA);
  wire       ind_wr  = wr_fire & (sel == `PIC_SEL_IND);
  wire       ind_rd  = rd_fire & (sel == `PIC_SEL_IND);
  wire       ctl_wr  = wr_fire & (sel == `PIC_SEL_CTRL);

  //////////////////////////////////////////////////////////////////////////////////
  // Bytes moved per interrupt
  wire [`PIC_XFER_W-1:0] xfer_lim = buffered_mode ? `PIC_XFER_BUF : `PIC_XFER_BYTE;
  wire                   xfer_ok  = (xfer_ff < xfer_lim);
  // Excess accesses past the limit are dropped silently
  wire byte_wr  = dat_wr & ~buffered_mode & xfer_ok;
  wire bufd_wr  = dat_wr & buffered_mode & xfer_ok;
  wire bufd_rd  = dat_rd & buffered_mode & xfer_ok;
  wire counted  = byte_wr | bufd_wr | bufd_rd;
  assign nxt_xfer = ctl_wr ? '0 : (xfer_ff + `PIC_XFER_W'(counted));

  //////////////////////////////////////////////////////////////////////////////////
  // Received bytes into the data register
  pic_skid #(
    .W     ($bits(pic_rx_s)),
    .DEPTH (2)
  ) u_skid (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .in_data   (rx_data),
    .out_valid (rxq_valid),
    .out_ready (rxq_ready),
    .out_data  (rxq_data)
  );
  // Draining stalls while the flag is up, so the byte on show stays put
  assign rxq_ready = ~ctrl_ff.si & ~byte_wr;
  wire rx_take   = rxq_valid & rxq_ready;
  wire rx_drop   = (rxq_data.arb_lost & buffered_mode) |
                   (rxq_data.own_addr & ~recog_ff);
  // Own-address bytes while recognised and arbitration-lost bytes in byte mode land like data
  wire rx_store  = rx_take & ~rx_drop;
  assign nxt_data = byte_wr  ? host_data_in :
                    rx_store ? rxq_data.data : data_ff;

  //////////////////////////////////////////////////////////////////////////////////
  // Interrupt request
  wire evt_ignored = evt_own_addr & ~recog_ff;
  wire evt_req     = evt_valid & (evt_status != `PIC_ST_IDLE) & ~evt_ignored;
  // The flag waits for the event's byte to reach the data register first
  wire si_set      = si_pend_ff & ~rxq_valid & ctrl_ff.enable;
  assign nxt_si_pend = evt_req | (si_pend_ff & ~si_set & ctrl_ff.enable);

  //////////////////////////////////////////////////////////////////////////////////
  // Control register next state
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (ctl_wr) begin
      nxt_ctrl.aa     = host_data_in[`PIC_CTRL_AA];
      nxt_ctrl.enable = host_data_in[`PIC_CTRL_ENABLE];
      nxt_ctrl.start  = host_data_in[`PIC_CTRL_START];
      nxt_ctrl.stop   = host_data_in[`PIC_CTRL_STOP];
      nxt_ctrl.mode   = host_data_in[`PIC_CTRL_MODE];
    end else if (stop_det) begin
      nxt_ctrl.stop   = 1'h0;
    end
    // Hardware set wins over the clearing write in the same cycle
    nxt_ctrl.si = si_set | (ctrl_ff.si & ~ctl_wr);
  end

  //////////////////////////////////////////////////////////////////////////////////
  // Slave release after the last transmitted byte
  wire aa_wr_set = ctl_wr & host_data_in[`PIC_CTRL_AA];
  always_comb begin
    nxt_slv = slv_ff;
    unique case (slv_ff)
      PIC_SLV_LISTEN: begin
        if (evt_valid & (evt_status == `PIC_ST_SLV_LAST)) nxt_slv = PIC_SLV_RELEASE_PEND;
      end
      PIC_SLV_RELEASE_PEND: begin
        // The clearing write may already set the flag again for later transfers
        if (ctl_wr) nxt_slv = PIC_SLV_RELEASED;
      end
      PIC_SLV_RELEASED: begin
        if (aa_wr_set | (ctrl_ff.aa & (start_det | stop_det))) nxt_slv = PIC_SLV_LISTEN;
      end
      default: nxt_slv = PIC_SLV_LISTEN;
    endcase
  end
  // Start and stop sensing and shifting go on in the engine while released
  wire nxt_recog = nxt_ctrl.aa & nxt_ctrl.enable & (nxt_slv == PIC_SLV_LISTEN);

  //////////////////////////////////////////////////////////////////////////////////
  // Indirect pointer and access strobes
  always_comb begin
    nxt_ind       = ind_ff;
    nxt_ind.wr    = ind_wr;
    nxt_ind.rd    = ind_rd;
    nxt_ind.wdata = ind_wr ? host_data_in : ind_ff.wdata;
    // Upper pointer bits are discarded, which also covers a careless host
    if (ptr_wr) nxt_ind.sel = host_data_in[`PIC_PTR_HI:0];
  end

  //////////////////////////////////////////////////////////////////////////////////
  // Read path
  assign ctrl_rdata[`PIC_CTRL_AA]                      = ctrl_ff.aa;
  assign ctrl_rdata[`PIC_CTRL_ENABLE]                  = ctrl_ff.enable;
  assign ctrl_rdata[`PIC_CTRL_START]                   = ctrl_ff.start;
  assign ctrl_rdata[`PIC_CTRL_STOP]                    = ctrl_ff.stop;
  assign ctrl_rdata[`PIC_CTRL_SI]                      = ctrl_ff.si;
  assign ctrl_rdata[`PIC_CTRL_RSV_HI:`PIC_CTRL_RSV_LO] = 2'h0;
  assign ctrl_rdata[`PIC_CTRL_MODE]                    = ctrl_ff.mode;
  wire [7:0] dat_rdata = buffered_mode ? buf_rdata : data_ff;
  always_comb begin
    unique case (sel)
      `PIC_SEL_PTR_STAT: rd_mux = bus_status_code;
      `PIC_SEL_DATA:     rd_mux = dat_rdata;
      `PIC_SEL_IND:      rd_mux = ind_rdata;
      `PIC_SEL_CTRL:     rd_mux = ctrl_rdata;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////////
  // Serial pins
  pic_line u_line (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .scl_in     (scl_in),
    .hold_req   (ctrl_ff.si & ctrl_ff.enable),
    .ack_slot   (ack_slot),
    .ack_case   (ack_case),
    .ack_assert (ctrl_ff.aa & ctrl_ff.enable),
    .recog_en   (recog_ff),
    .scl_oe     (scl_oe),
    .sda_oe     (sda_oe)
  );

  //////////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_ff <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      slv_ff <= PIC_SLV_LISTEN;
    end else begin
      slv_ff <= nxt_slv;
    end
  end

  // Indirect strobes last one cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ind_ff <= '{sel: `PIC_RST_PTR, wr: 1'h0, rd: 1'h0, wdata: 8'h00};
    end else begin
      ind_ff <= nxt_ind;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_ff <= `PIC_RST_DATA;
    end else begin
      data_ff <= nxt_data;
    end
  end

  // Cleared by every control write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      xfer_ff <= '0;
    end else begin
      xfer_ff <= nxt_xfer;
    end
  end

  // Strobe history for the edge detect
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_act_ff <= 1'h0;
      rd_act_ff <= 1'h0;
    end else begin
      wr_act_ff <= wr_act;
      rd_act_ff <= rd_act;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      si_pend_ff <= 1'h0;
    end else begin
      si_pend_ff <= nxt_si_pend;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      recog_ff <= 1'h0;
    end else begin
      recog_ff <= nxt_recog;
    end
  end

  // Pins only pull low, pull-ups give high
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_oe_ff <= 1'h0;
    end else begin
      int_oe_ff <= nxt_ctrl.si & nxt_ctrl.enable;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_low_ff <= 1'h0;
    end else begin
      pin_low_ff <= 1'h0;
    end
  end

  // Read data follows the select pins for as long as the strobe is low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dout_ff <= 8'h00;
      doe_ff  <= 1'h0;
    end else begin
      dout_ff <= rd_mux;
      doe_ff  <= rd_act;
    end
  end

  // Pulses toward the engine buffer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      buf_wr_ff    <= 1'h0;
      buf_rd_ff    <= 1'h0;
      buf_wdata_ff <= 8'h00;
    end else begin
      buf_wr_ff    <= bufd_wr;
      buf_rd_ff    <= bufd_rd;
      buf_wdata_ff <= bufd_wr ? host_data_in : buf_wdata_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign host_data_out = dout_ff;
  assign host_data_oe  = doe_ff;
  assign int_n_out     = pin_low_ff;
  assign int_n_oe      = int_oe_ff;
  assign scl_out       = pin_low_ff;
  assign sda_out       = pin_low_ff;
  assign tx_byte       = data_ff;
  assign ctrl          = ctrl_ff;
  assign recog_en      = recog_ff;
  assign ind           = ind_ff;
  assign buf_wr        = buf_wr_ff;
  assign buf_rd        = buf_rd_ff;
  assign buf_wdata     = buf_wdata_ff;
endmodule // pic_regs

// *** tb/pic_regs_monitor.sv ***
// Concurrent checks on the controller register set ports
`timescale 1ns/1ps
module pic_regs_monitor (
  input wire logic                   clk_sys,
  input wire logic                   rst,
  input wire logic                   cs_n,
  input wire logic                   wr_n,
  input wire logic                   register_select_low,
  input wire logic                   register_select_high,
  input wire logic [7:0]             host_data_in,
  input wire logic                   int_n_oe,
  input wire logic                   scl_in,
  input wire logic                   scl_oe,
  input wire logic                   sda_oe,
  input wire logic                   evt_valid,
  input wire logic [7:0]             evt_status,
  input wire logic                   evt_own_addr,
  input wire logic                   stop_det,
  input wire logic                   ack_slot,
  input wire pic_pkg::pic_ack_case_e ack_case,
  input wire logic [7:0]             tx_byte,
  input wire pic_pkg::pic_ctrl_s     ctrl,
  input wire logic                   recog_en,
  input wire pic_pkg::pic_ind_s      ind
);
  import pic_pkg::*;
  ////////////////////////////////////////
  logic             wr_d_ff;
  wire logic        wr_act = !cs_n && !wr_n;
  wire logic        lead   = wr_act && !wr_d_ff;
  wire logic [1:0]  sel    = {register_select_high, register_select_low};
  wire logic [2:0]  ptr_in = host_data_in[2:0];
  // A held strobe counts once, so writes are keyed on the leading edge
  always_ff @(posedge clk_sys) wr_d_ff <= wr_act;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  property p_ack; ack_slot && ctrl.aa && ctrl.enable &&
    (ack_case == PIC_ACK_MST_RX || ack_case == PIC_ACK_SLV_RX) |=> sda_oe; endproperty
  a_ack: assert property (p_ack) else $error("ack not driven");
  property p_nak; ack_slot && !ctrl.aa |=> !sda_oe; endproperty
  a_nak: assert property (p_nak) else $error("ack driven with flag clear");
  property p_hold; ctrl.si && !scl_in |=> scl_oe; endproperty
  a_hold: assert property (p_hold) else $error("clock not held low");
  property p_wrc; lead && sel == 2'h3 && !evt_valid && !$past(evt_valid)
    |=> !ctrl.si && !int_n_oe; endproperty
  a_wrc: assert property (p_wrc) else $error("flag or line kept after write");
  property p_evt; evt_valid && evt_status != 8'hF8 && ctrl.enable && recog_en
    |-> ##[1:8] ctrl.si && int_n_oe; endproperty
  a_evt: assert property (p_evt) else $error("event raised no interrupt");
  property p_rel; evt_valid && evt_own_addr && !recog_en && !ctrl.si |=> !ctrl.si; endproperty
  a_rel: assert property (p_rel) else $error("released slave interrupted");
  property p_stop; stop_det && !(lead && sel == 2'h3) |=> !ctrl.stop; endproperty
  a_stop: assert property (p_stop) else $error("stop flag kept");
  property p_dat; ctrl.si && !(wr_act && sel == 2'h1) |=> $stable(tx_byte); endproperty
  a_dat: assert property (p_dat) else $error("data changed under flag");
  property p_ptr; lead && sel == 2'h0 |=> ind.sel == $past(ptr_in); endproperty
  a_ptr: assert property (p_ptr) else $error("pointer index wrong");
  property p_ind; lead && sel == 2'h2 |=> ind.wr && ind.wdata == $past(host_data_in); endproperty
  a_ind: assert property (p_ind) else $error("indirect write lost");
endmodule // pic_regs_monitor

bind pic_regs pic_regs_monitor u_mon (.*);

// *** tb/pic_host_model.sv ***
// Parallel bus host that reaches the direct registers
`timescale 1ns/1ps
module pic_host_model (
  input wire logic        clk_sys,
  input wire logic [7:0]  host_data_out,
  output logic            cs_n,
  output logic            wr_n,
  output logic            rd_n,
  output logic            register_select_low,
  output logic            register_select_high,
  output logic [7:0]      host_data_in
);
  initial begin
    {cs_n, wr_n, rd_n} = 3'h7;
    {register_select_high, register_select_low} = 2'h0;
    host_data_in = 8'h00;
  end
  ////////////////////////////////////////
  // Strobe stays high at least one cycle between calls, so each access is a new edge
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk_sys);
    #2;
    {register_select_high, register_select_low} = s;
    host_data_in = (s == 2'h0) ? {5'h00, d[2:0]} : d;
    {cs_n, wr_n} = 2'h0;
    @(posedge clk_sys);
    #2;
    {cs_n, wr_n} = 2'h3;
    // Released bus must not look like the last byte
    host_data_in = ~host_data_in;
  endtask
  task automatic rd(input logic [1:0] s, output logic [7:0] d);
    @(posedge clk_sys);
    #2;
    {register_select_high, register_select_low} = s;
    {cs_n, rd_n} = 2'h0;
    @(posedge clk_sys);
    #2;
    d = host_data_out;
    {cs_n, rd_n} = 2'h3;
  endtask
endmodule // pic_host_model

// *** tb/tb_parallel_i2c_ctrl_regs.sv ***
// Self-checking bench of the controller register set
`timescale 1ns/1ps
module tb_parallel_i2c_ctrl_regs;
  import pic_pkg::*;
  logic          clk_sys = 1'h0, rst = 1'h1;
  wire logic     cs_n, wr_n, rd_n, register_select_low, register_select_high;
  wire logic [7:0] host_data_in;
  logic [7:0]    host_data_out, tx_byte, buf_wdata, d;
  logic [7:0]    evt_status = 8'h00, bus_status_code = 8'hF8;
  logic [7:0]    ind_rdata = 8'h00, buf_rdata = 8'h00;
  logic          host_data_oe, int_n_out, int_n_oe, scl_out, scl_oe, sda_out, sda_oe;
  logic          rx_ready, recog_en, buf_wr, buf_rd;
  logic          scl_in = 1'h1, evt_valid = 1'h0, evt_own_addr = 1'h0, start_det = 1'h0;
  logic          stop_det = 1'h0, ack_slot = 1'h0, buffered_mode = 1'h0, rx_valid = 1'h0;
  pic_ack_case_e ack_case = PIC_ACK_NONE;
  pic_rx_s       rx_data = '0;
  pic_ctrl_s     ctrl;
  pic_ind_s      ind;
  int            failures = 0, n_compared = 0, cycles = 0;
  pic_regs DUT (.*);
  pic_host_model host (.*);
  always #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Whole run is well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic evt(input logic [7:0] s, input logic o);
    {evt_status, evt_own_addr, evt_valid} = {s, o, 1'h1};
    tick(1);
    evt_valid = 1'h0;
  endtask
  task automatic wait_si();
    for (int i = 0; i < 20 && ctrl.si !== 1'h1; i++) tick(1);
  endtask
  task automatic send(input logic [7:0] b, input logic al, input logic oa);
    rx_data = '{b, al, oa};
    rx_valid = 1'h1;
    tick(1);
    rx_valid = 1'h0;
    tick(3);
  endtask
  ////////////////////////////////////////
  task automatic t_reg();
    host.rd(2'h3, d);
    chk("control reset", 8'h00, d);
    chk1("read drive", 1'h1, host_data_oe);
    host.rd(2'h1, d);
    chk("data reset", 8'h00, d);
    host.wr(2'h3, 8'hC7);
    host.rd(2'h3, d);
    chk("control readback", 8'hC1, d);
    host.wr(2'h3, 8'hC0);
    host.wr(2'h0, 8'h05);
    chk("pointer", 8'h05, {5'h00, ind.sel});
    ind_rdata = 8'h5A;
    host.rd(2'h2, d);
    chk("indirect read", 8'h5A, d);
    host.wr(2'h2, 8'h3C);
    $display("test registers done");
  endtask
  task automatic t_evt();
    scl_in = 1'h0;
    bus_status_code = 8'h08;
    evt(8'h08, 1'h0);
    wait_si();
    chk1("flag set", 1'h1, ctrl.si);
    chk1("int line", 1'h1, int_n_oe);
    tick(1);
    chk1("scl hold", 1'h1, scl_oe);
    chk("pin levels", 8'h00, {5'h00, int_n_out, scl_out, sda_out});
    host.rd(2'h0, d);
    chk("status", 8'h08, d);
    host.wr(2'h3, 8'hC0);
    tick(1);
    chk1("flag clear", 1'h0, ctrl.si);
    chk1("int release", 1'h0, int_n_oe);
    tick(1);
    chk1("scl release", 1'h0, scl_oe);
    evt(8'hF8, 1'h0);
    tick(3);
    chk1("idle event", 1'h0, ctrl.si);
    scl_in = 1'h1;
    $display("test events done");
  endtask
  task automatic t_rx();
    send(8'hA5, 1'h0, 1'h0);
    chk("received", 8'hA5, tx_byte);
    host.rd(2'h1, d);
    chk("data read", 8'hA5, d);
    evt(8'h80, 1'h0);
    wait_si();
    rx_data = '{8'h3C, 1'h0, 1'h0};
    rx_valid = 1'h1;
    tick(4);
    chk1("buffer full", 1'h0, rx_ready);
    rx_valid = 1'h0;
    chk("held under flag", 8'hA5, tx_byte);
    host.wr(2'h1, 8'h66);
    host.wr(2'h1, 8'h77);
    chk("one byte", 8'h66, tx_byte);
    host.wr(2'h3, 8'hC0);
    tick(4);
    chk("drained", 8'h3C, tx_byte);
    chk1("buffer empty", 1'h1, rx_ready);
    $display("test receive done");
  endtask
  task automatic t_arb();
    buffered_mode = 1'h1;
    send(8'hE1, 1'h1, 1'h0);
    chk("buffered loss", 8'h3C, tx_byte);
    evt(8'h80, 1'h0);
    wait_si();
    for (int i = 0; i < 69; i++) begin
      host.wr(2'h1, 8'(i));
      chk1("buffer write", i < 68, buf_wr);
    end
    chk("buffer data", 8'h43, buf_wdata);
    host.wr(2'h3, 8'hC0);
    buffered_mode = 1'h0;
    send(8'hE1, 1'h1, 1'h0);
    chk("byte loss", 8'hE1, tx_byte);
    send(8'h42, 1'h0, 1'h1);
    chk("own address", 8'h42, tx_byte);
    $display("test arbitration done");
  endtask
  task automatic t_ack();
    ack_slot = 1'h1;
    for (int a = 1; a >= 0; a--) begin
      host.wr(2'h3, a ? 8'hC0 : 8'h40);
      for (int c = 1; c < 4; c++) begin
        ack_case = pic_ack_case_e'(c);
        tick(1);
        chk1("ack drive", a[0], sda_oe);
      end
    end
    ack_slot = 1'h0;
    host.wr(2'h3, 8'hC0);
    $display("test acknowledge done");
  endtask
  task automatic t_rel();
    evt(8'hC8, 1'h0);
    wait_si();
    host.wr(2'h3, 8'hC0);
    tick(2);
    chk1("released", 1'h0, recog_en);
    evt(8'h60, 1'h1);
    tick(4);
    chk1("no interrupt", 1'h0, ctrl.si);
    host.wr(2'h3, 8'hC0);
    tick(1);
    chk1("recognition back", 1'h1, recog_en);
    evt(8'hC8, 1'h0);
    wait_si();
    host.wr(2'h3, 8'hC0);
    chk1("released again", 1'h0, recog_en);
    start_det = 1'h1;
    tick(1);
    start_det = 1'h0;
    chk1("start resume", 1'h1, recog_en);
    host.wr(2'h3, 8'hD0);
    chk1("stop set", 1'h1, ctrl.stop);
    stop_det = 1'h1;
    tick(1);
    stop_det = 1'h0;
    tick(1);
    chk1("stop cleared", 1'h0, ctrl.stop);
    $display("test release done");
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    #2;
    rst = 1'h0;
    t_reg();
    t_evt();
    t_rx();
    t_arb();
    t_ack();
    t_rel();
    tally_and_finish();
  end
endmodule // tb_parallel_i2c_ctrl_regs
